// >>> logic/mipss_io_ports.sv
// io ports and serial nibble register behind an apb slave
// Notes on behaviour
// RL1: input read returns all four lines together
// RL2: lines zero, three latch falling edges
// RL3: line one requests interrupt when enabled
// RL4: line two may feed time base
// RL5: octal port drives its holding register
// RL6: octal drivers can float for bus sharing
// RL7: second octal latch loaded by program only
// RL8: external source pulls low or drives both
// RL9: general nibble port latched, pins readable
// RL10: nibble pin levels never enter latches
// RL11: auxiliary nibble port like general port
// RL12: each nibble line has own direction
// RL13: digit output loads from digit address
// RL14: serial register counts or shifts by mode
// RL15: counter decrements after two-cycle low pulse
// RL16: counter mode outputs are program levels
// RL17: shift mode shifts, clock toggles per cycle
// RL18: data and clock outputs forceable low
// RL19: input reaches output four cycles later
// RL20: shifting continues whatever outputs show
// RL21: shift left, input lsb, output msb
// RL22: enable bit zero selects counter mode
// RL23: enable bit three gates serial output
// RL24: enable bit two gates octal drivers
// RL25: reset clears enable register to zero
`timescale 1ns/100ps
module mipss_io_ports
  import mipss_pkg::*;
#(
  parameter int INSTR_CYC = MIPSS_INSTR_CYC
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // four-line input port
  input wire logic [3:0] in_pins,
  // octal bus port
  input wire logic [7:0] oct_in,
  output logic [7:0] oct_out,
  output logic [7:0] oct_oe,
  // second octal port
  input wire logic [7:0] aux8_in,
  output logic [7:0] aux8_out,
  output logic [7:0] aux8_oe,
  // general nibble port
  input wire logic [3:0] gen4_in,
  output logic [3:0] gen4_out,
  output logic [3:0] gen4_oe,
  // auxiliary nibble port
  input wire logic [3:0] aux4_in,
  output logic [3:0] aux4_out,
  output logic [3:0] aux4_oe,
  // digit output port
  output logic [3:0] digit_out,
  // serial three-wire link
  input wire logic serial_in_pin,
  output logic serial_out_pin,
  output logic serial_clock_pin,
  // core side events
  output logic int_req,
  output logic time_base_tick
);

  // elaboration check on instruction cycle length
  if (INSTR_CYC < 4 || (INSTR_CYC % 2) != 0) begin : g_bad_cyc
    $error("INSTR_CYC must be even and at least 4");
  end

  // divider width and its end and half points
  localparam int DW = $clog2(INSTR_CYC);
  localparam logic [DW-1:0] DIV_LAST = DW'(INSTR_CYC - 1);
  localparam logic [DW-1:0] DIV_HALF = DW'(INSTR_CYC / 2);

  // whole state of the block
  typedef struct packed {
    // two-flop pin synchronisers
    logic [3:0] in_s1;
    logic [3:0] in_s2;
    logic [3:0] in_prev;
    logic [7:0] oct_s1;
    logic [7:0] oct_s2;
    logic [7:0] aux8_s1;
    logic [7:0] aux8_s2;
    logic [3:0] gen4_s1;
    logic [3:0] gen4_s2;
    logic [3:0] aux4_s1;
    logic [3:0] aux4_s2;
    logic si_s1;
    logic si_s2;
    // program visible registers and capture flags
    logic [7:0] enable_reg;
    logic [1:0] cap;
    logic irq;
    logic [7:0] oct_q;
    logic [7:0] aux8_q;
    logic [3:0] gen4_q;
    logic [3:0] aux4_q;
    logic [7:0] dir4;
    logic [3:0] digit_addr;
    logic [3:0] digit_q;
    // serial register, clock level and cycle timing
    logic [3:0] serial_nibble_register;
    logic skl;
    logic [DW-1:0] div;
    logic [1:0] pre;
    logic [1:0] low_cnt;
    logic armed;
    logic so;
    logic clk_q;
    // registered pin enables and bus answer
    logic [7:0] oct_oe;
    logic [7:0] aux8_oe;
    logic [3:0] gen4_oe;
    logic [3:0] aux4_oe;
    logic tb_tick;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mipss_state_t;

  mipss_state_t st_reg; // registered state
  mipss_state_t st_next; // next state

  // decoded helper terms
  logic instr_tick; // end of an instruction cycle
  logic acc_done; // apb access completes this edge
  logic wr_en; // write takes effect
  logic rd_done; // read completes
  logic [31:0] rd_val; // read mux value
  logic rd_hit; // address maps to a register
  logic mode_count; // serial register counts
  logic fall_cap0; // falling edge line zero
  logic fall_cap3; // falling edge line three
  logic fall_irq; // falling edge line one
  logic fall_tb; // falling edge line two
  logic prescale_tick; // internal time base source

  // next state logic
  always_comb begin
    // every field holds unless a branch below moves it
    st_next = st_reg;
    instr_tick = (st_reg.div == DIV_LAST);
    // apb completes when ready was already high
    acc_done = psel & penable & st_reg.pready;
    wr_en = acc_done & pwrite;
    rd_done = acc_done & ~pwrite;
    // enable bit zero picks counter mode
    mode_count = st_reg.enable_reg[MIPSS_EN_MODE];
    // falling edges: last synced level high, new one low
    fall_cap0 = st_reg.in_prev[MIPSS_LINE_CAP0] & ~st_reg.in_s2[MIPSS_LINE_CAP0];
    fall_cap3 = st_reg.in_prev[MIPSS_LINE_CAP3] & ~st_reg.in_s2[MIPSS_LINE_CAP3];
    fall_irq = st_reg.in_prev[MIPSS_LINE_IRQ] & ~st_reg.in_s2[MIPSS_LINE_IRQ];
    fall_tb = st_reg.in_prev[MIPSS_LINE_TB] & ~st_reg.in_s2[MIPSS_LINE_TB];
    // one pulse every fourth instruction cycle
    prescale_tick = instr_tick & (st_reg.pre == MIPSS_PRESCALE_MAX);

    // two-flop synchronisers for every pin input
    st_next.in_s1 = in_pins;
    st_next.in_s2 = st_reg.in_s1;
    // edge history one flop behind the second stage
    st_next.in_prev = st_reg.in_s2;
    st_next.oct_s1 = oct_in;
    st_next.oct_s2 = st_reg.oct_s1;
    st_next.aux8_s1 = aux8_in;
    st_next.aux8_s2 = st_reg.aux8_s1;
    st_next.gen4_s1 = gen4_in;
    st_next.gen4_s2 = st_reg.gen4_s1;
    st_next.aux4_s1 = aux4_in;
    st_next.aux4_s2 = st_reg.aux4_s1;
    // serial input synchroniser
    st_next.si_s1 = serial_in_pin;
    st_next.si_s2 = st_reg.si_s1;

    // instruction cycle divider and prescaler
    if (instr_tick) begin
      // wrap and advance the prescaler
      st_next.div = '0;
      st_next.pre = st_reg.pre + 2'h1;
    end else begin
      // count sys_clk within the cycle
      st_next.div = st_reg.div + DW'(1);
    end

    // read mux
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    case (paddr)
      MIPSS_ENABLE_OFS: rd_val[7:0] = st_reg.enable_reg;
      // RL1: all four lines as one value
      MIPSS_IN_LVL_OFS: rd_val[3:0] = st_reg.in_s2;
      MIPSS_IN_CAP_OFS: rd_val[1:0] = st_reg.cap;
      MIPSS_OCT_Q_OFS: rd_val[7:0] = st_reg.oct_q;
      // RL5: pin reads come from the pins
      MIPSS_OCT_PIN_OFS: rd_val[7:0] = st_reg.oct_s2;
      MIPSS_AUX8_OFS: rd_val[7:0] = st_reg.aux8_q;
      MIPSS_AUX8_PIN_OFS: rd_val[7:0] = st_reg.aux8_s2;
      MIPSS_GEN4_OFS: rd_val[3:0] = st_reg.gen4_q;
      // RL9: direct line test, bit 4 flags all low
      MIPSS_GEN4_PIN_OFS: rd_val[4:0] = {~|st_reg.gen4_s2, st_reg.gen4_s2};
      MIPSS_AUX4_OFS: rd_val[3:0] = st_reg.aux4_q;
      // RL11: plain pin read, no test flag
      MIPSS_AUX4_PIN_OFS: rd_val[3:0] = st_reg.aux4_s2;
      MIPSS_DIR4_OFS: rd_val[7:0] = st_reg.dir4;
      MIPSS_DOUT_LOAD_OFS: rd_val[3:0] = st_reg.digit_q;
      MIPSS_DIGIT_OFS: rd_val[3:0] = st_reg.digit_addr;
      // serial register reads show its current value
      MIPSS_SERIAL_OFS: rd_val[3:0] = st_reg.serial_nibble_register;
      // clock level bit and interrupt flag
      MIPSS_SKL_OFS: rd_val[0] = st_reg.skl;
      MIPSS_IRQ_OFS: rd_val[0] = st_reg.irq;
      default: rd_hit = 1'b0;
    endcase
    // misaligned addresses answer with an error
    if (paddr[1:0] != 2'h0) begin
      rd_hit = 1'b0;
    end

    // apb: one wait state, answer latched with pready
    // ready rises on the first access edge, one cycle after penable
    st_next.pready = psel & penable & ~st_reg.pready;
    if (psel & penable & ~st_reg.pready) begin
      // first access edge: capture data and error
      st_next.prdata = pwrite ? 32'h0000_0000 : rd_val;
      st_next.pslverr = ~rd_hit;
    end else if (acc_done) begin
      // completing edge: drop the error
      st_next.pslverr = 1'b0;
    end

    // capture latches cleared by read, only bits returned
    if (rd_done && paddr == MIPSS_IN_CAP_OFS) begin
      // clear only the bits this read returned
      st_next.cap = st_reg.cap & ~st_reg.prdata[1:0];
    end
    if (rd_done && paddr == MIPSS_IRQ_OFS) begin
      // flag returned by this read is cleared
      st_next.irq = st_reg.irq & ~st_reg.prdata[0];
    end
    // RL2: falling edges set latches, set wins
    if (fall_cap0) begin
      st_next.cap[0] = 1'b1;
    end
    if (fall_cap3) begin
      st_next.cap[1] = 1'b1;
    end
    // RL3: line one counts only with interrupts on
    if (fall_irq && st_reg.enable_reg[MIPSS_EN_IRQ]) begin
      st_next.irq = 1'b1;
    end

    // RL4: time base source select
    st_next.tb_tick = st_reg.enable_reg[MIPSS_EN_TBSRC] ? fall_tb : prescale_tick;

    // register writes
    // refused addresses never reach a register
    if (wr_en && !st_reg.pslverr) begin
      case (paddr)
        MIPSS_ENABLE_OFS: st_next.enable_reg = pwdata[7:0];
        // RL7: second octal latch written only here
        MIPSS_AUX8_OFS: st_next.aux8_q = pwdata[7:0];
        MIPSS_OCT_Q_OFS: st_next.oct_q = pwdata[7:0];
        // RL10: nibble latches hold program data only
        MIPSS_GEN4_OFS: st_next.gen4_q = pwdata[3:0];
        MIPSS_AUX4_OFS: st_next.aux4_q = pwdata[3:0];
        MIPSS_DIR4_OFS: st_next.dir4 = pwdata[7:0];
        // RL13: digit output copies digit address
        MIPSS_DOUT_LOAD_OFS: st_next.digit_q = st_reg.digit_addr;
        // digit address is a plain program register
        MIPSS_DIGIT_OFS: st_next.digit_addr = pwdata[3:0];
        MIPSS_SKL_OFS: st_next.skl = pwdata[0];
        // other offsets are read-only, unmapped, or the serial register written below
        default: st_next.skl = st_reg.skl;
      endcase
    end

    // RL22: bit zero picks counter or shifter
    if (mode_count) begin
      // counter mode arms on a high level
      if (st_reg.si_s2) begin
        // high input re-arms and restarts the low count
        st_next.armed = 1'b1;
        st_next.low_cnt = 2'h0;
      end else if (instr_tick && st_reg.armed) begin
        // low for one more instruction cycle
        st_next.low_cnt = st_reg.low_cnt + 2'h1;
        // RL15: decrement after two low cycles
        if (st_reg.low_cnt + 2'h1 == MIPSS_LOW_MIN) begin
          st_next.serial_nibble_register = st_reg.serial_nibble_register - 4'h1;
          st_next.armed = 1'b0;
        end
      end
      // RL16: outputs are program levels
      st_next.so = st_reg.enable_reg[MIPSS_EN_SO];
      st_next.clk_q = st_reg.skl;
    end else begin
      // shift mode: counter must re-arm on entry
      st_next.armed = 1'b0;
      st_next.low_cnt = 2'h0;
      // RL20: shifting each cycle regardless
      if (instr_tick) begin
        // RL21: input into lsb, msb toward output
        st_next.serial_nibble_register = {st_reg.serial_nibble_register[2:0], st_reg.si_s2};
      end
      // RL23: output gated by enable bit three
      // RL18: data forced low when disabled
      st_next.so = st_reg.enable_reg[MIPSS_EN_SO] & st_reg.serial_nibble_register[3];
      // RL17: clock high in first half of cycle
      // RL18: clock forced low when level bit clear
      st_next.clk_q = st_reg.skl & (st_reg.div < DIV_HALF);
    end
    // RL14: program write overrides count or shift
    // RL19: only a program write breaks the delay
    if (wr_en && !st_reg.pslverr && paddr == MIPSS_SERIAL_OFS) begin
      // program load wins this edge
      st_next.serial_nibble_register = pwdata[3:0];
    end

    // RL24: octal drivers follow enable bit two
    // RL6: cleared bit floats the octal pins
    st_next.oct_oe = {8{st_next.enable_reg[MIPSS_EN_OCT]}};
    // second octal drivers follow enable bit seven
    st_next.aux8_oe = {8{st_next.enable_reg[MIPSS_EN_AUX8]}};
    // RL12: per-line direction on nibble ports
    st_next.gen4_oe = st_next.dir4[3:0];
    st_next.aux4_oe = st_next.dir4[7:4];
  end

  // RL25: reset clears enable and all state
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      // bidirectional pins float, digit and serial outputs low
      st_reg <= '0;
      // reset values on top of the cleared state
      st_reg.enable_reg <= MIPSS_ENABLE_RST;
      st_reg.serial_nibble_register <= MIPSS_SNR_RST;
    end else begin
      // register the whole state each edge
      st_reg <= st_next;
    end
  end

  // outputs straight from flops
  assign prdata = st_reg.prdata;
  assign pready = st_reg.pready;
  assign pslverr = st_reg.pslverr;
  // RL5: octal pins show holding register
  assign oct_out = st_reg.oct_q;
  assign oct_oe = st_reg.oct_oe;
  assign aux8_out = st_reg.aux8_q;
  assign aux8_oe = st_reg.aux8_oe;
  // nibble ports and digit latch
  assign gen4_out = st_reg.gen4_q;
  assign gen4_oe = st_reg.gen4_oe;
  assign aux4_out = st_reg.aux4_q;
  assign aux4_oe = st_reg.aux4_oe;
  assign digit_out = st_reg.digit_q;
  // serial pins and core events
  assign serial_out_pin = st_reg.so;
  assign serial_clock_pin = st_reg.clk_q;
  assign int_req = st_reg.irq;
  assign time_base_tick = st_reg.tb_tick;

endmodule

// >>> logic/mipss_pkg.sv
// shared constants for the port and serial shift block
package mipss_pkg;
  // apb register byte offsets
  localparam logic [7:0] MIPSS_ENABLE_OFS = 8'h00;
  localparam logic [7:0] MIPSS_IN_LVL_OFS = 8'h04;
  localparam logic [7:0] MIPSS_IN_CAP_OFS = 8'h08;
  localparam logic [7:0] MIPSS_OCT_Q_OFS = 8'h0c;
  localparam logic [7:0] MIPSS_OCT_PIN_OFS = 8'h10;
  localparam logic [7:0] MIPSS_AUX8_OFS = 8'h14;
  localparam logic [7:0] MIPSS_AUX8_PIN_OFS = 8'h18;
  localparam logic [7:0] MIPSS_GEN4_OFS = 8'h1c;
  localparam logic [7:0] MIPSS_GEN4_PIN_OFS = 8'h20;
  localparam logic [7:0] MIPSS_AUX4_OFS = 8'h24;
  localparam logic [7:0] MIPSS_AUX4_PIN_OFS = 8'h28;
  localparam logic [7:0] MIPSS_DIR4_OFS = 8'h2c;
  localparam logic [7:0] MIPSS_DOUT_LOAD_OFS = 8'h30;
  localparam logic [7:0] MIPSS_DIGIT_OFS = 8'h34;
  localparam logic [7:0] MIPSS_SERIAL_OFS = 8'h38;
  localparam logic [7:0] MIPSS_SKL_OFS = 8'h3c;
  localparam logic [7:0] MIPSS_IRQ_OFS = 8'h40;
  // enable register field positions
  localparam int MIPSS_EN_MODE = 0;
  localparam int MIPSS_EN_IRQ = 1;
  localparam int MIPSS_EN_OCT = 2;
  localparam int MIPSS_EN_SO = 3;
  localparam int MIPSS_EN_TBSRC = 6;
  localparam int MIPSS_EN_AUX8 = 7;
  // input line positions
  localparam int MIPSS_LINE_CAP0 = 0;
  localparam int MIPSS_LINE_IRQ = 1;
  localparam int MIPSS_LINE_TB = 2;
  localparam int MIPSS_LINE_CAP3 = 3;
  // reset values
  localparam logic [7:0] MIPSS_ENABLE_RST = 8'h00;
  localparam logic [3:0] MIPSS_SNR_RST = 4'h0;
  // instruction cycle timing
  localparam int MIPSS_INSTR_NS = 160;
  localparam int MIPSS_CLK_MHZ = 250;
  localparam int MIPSS_INSTR_CYC = (MIPSS_INSTR_NS * MIPSS_CLK_MHZ) / 1000;
  // counter mode needs the serial input low this many instruction cycles
  localparam logic [1:0] MIPSS_LOW_MIN = 2'h2;
  // time base prescaler divide ratio minus one
  localparam logic [1:0] MIPSS_PRESCALE_MAX = 2'h3;
endpackage

// >>> verification/mipss_io_ports_chk.sv
// port-level checker for the io port block
`timescale 1ns/100ps
module mipss_io_ports_chk
  import mipss_pkg::*;
(
  // clock reset and apb
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  // port outputs
  input wire logic [7:0] oct_out,
  input wire logic [7:0] oct_oe,
  input wire logic [7:0] aux8_out,
  input wire logic [3:0] gen4_out,
  input wire logic [3:0] aux4_out,
  input wire logic [3:0] digit_out,
  input wire logic serial_out_pin,
  input wire logic time_base_tick
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // last completed write and its address
  logic wd_reg;
  logic [7:0] wa_reg;
  // remember each finished write
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wd_reg <= 1'b0;
      wa_reg <= 8'h00;
    end else begin
      wd_reg <= psel && penable && pready && pwrite;
      wa_reg <= paddr;
    end
  end
  a_oct_prog_only: assert property ($changed(oct_out) |-> wd_reg && wa_reg == MIPSS_OCT_Q_OFS)
    else $error("octal latch changed without a write");
  a_aux8_prog_only: assert property ($changed(aux8_out) |-> wd_reg && wa_reg == MIPSS_AUX8_OFS)
    else $error("second octal latch changed without a write");
  a_gen4_prog_only: assert property ($changed(gen4_out) |-> wd_reg && wa_reg == MIPSS_GEN4_OFS)
    else $error("nibble latch changed without a write");
  a_aux4_prog_only: assert property ($changed(aux4_out) |-> wd_reg && wa_reg == MIPSS_AUX4_OFS)
    else $error("aux nibble latch changed without a write");
  a_digit_cmd_only: assert property ($changed(digit_out) |-> wd_reg && wa_reg == MIPSS_DOUT_LOAD_OFS)
    else $error("digit output changed without a load");
  a_oct_oe_cause: assert property ($changed(oct_oe) |-> wd_reg && wa_reg == MIPSS_ENABLE_OFS
    && (oct_oe == 8'h00 || oct_oe == 8'hff))
    else $error("octal enables changed wrongly");
  a_reset_quiet: assert property ($rose(rstn) |-> oct_oe == 8'h00 && !serial_out_pin)
    else $error("outputs not quiet after reset");
  a_tick_pulse: assert property (time_base_tick |=> !time_base_tick)
    else $error("time base tick longer than one cycle");
  a_ready_once: assert property (pready |=> !pready)
    else $error("ready held two cycles");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  // main scenarios seen
  c_oct_write: cover property (wd_reg && wa_reg == MIPSS_OCT_Q_OFS);
  c_err: cover property (pslverr);
  c_so_rise: cover property ($rose(serial_out_pin));
endmodule
bind mipss_io_ports mipss_io_ports_chk chk (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pready,
  .pslverr, .oct_out, .oct_oe, .aux8_out, .gen4_out, .aux4_out, .digit_out, .serial_out_pin, .time_base_tick);

// >>> verification/mipss_pin_res.sv
// outside world model for one bidirectional port
`timescale 1ns/100ps
module mipss_pin_res #(
  parameter int W = 8
) (
  // design side
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  // outside source level
  input wire logic [W-1:0] ext,
  // resolved pin level
  output logic [W-1:0] pin
);
  // driven ones act as pull-up
  // outside source only needs to pull low
  assign pin = ext & (out | ~oe);
endmodule

// >>> verification/test_mcu_io_ports_serial_shift.sv
// self-checking bench for the io port block
`timescale 1ns/100ps
module test_mcu_io_ports_serial_shift
  import mipss_pkg::*;
;
  // clock reset and apb
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  // pins and outside sources
  logic [3:0] in_pins = 4'hf;
  logic si = 1'b1;
  logic so, sclk, sclk_prev, irq, tick;
  logic [7:0] oct_x = 8'hff, aux8_x = 8'hff, oct_o, oct_e, oct_p, aux8_o, aux8_e, aux8_p;
  logic [3:0] gen4_x = 4'hf, aux4_x = 4'hf, gen4_o, gen4_e, gen4_p, aux4_o, aux4_e, aux4_p, digit;
  int fail_count = 0;
  int cmp_count = 0;
  int n, k;
  // 250 MHz clock
  always #2 sys_clk = ~sys_clk;
  mipss_io_ports dut (.sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .in_pins, .oct_in(oct_p), .oct_out(oct_o), .oct_oe(oct_e), .aux8_in(aux8_p),
    .aux8_out(aux8_o), .aux8_oe(aux8_e), .gen4_in(gen4_p), .gen4_out(gen4_o), .gen4_oe(gen4_e),
    .aux4_in(aux4_p), .aux4_out(aux4_o), .aux4_oe(aux4_e), .digit_out(digit), .serial_in_pin(si),
    .serial_out_pin(so), .serial_clock_pin(sclk), .int_req(irq), .time_base_tick(tick));
  // outside drivers of the four bidirectional ports
  mipss_pin_res #(8) r_oct (.out(oct_o), .oe(oct_e), .ext(oct_x), .pin(oct_p));
  mipss_pin_res #(8) r_aux8 (.out(aux8_o), .oe(aux8_e), .ext(aux8_x), .pin(aux8_p));
  mipss_pin_res #(4) r_gen4 (.out(gen4_o), .oe(gen4_e), .ext(gen4_x), .pin(gen4_p));
  mipss_pin_res #(4) r_aux4 (.out(aux4_o), .oe(aux4_e), .ext(aux4_x), .pin(aux4_p));
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // counts and verdict
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic cyc(input int c);
    repeat (c) @(posedge sys_clk);
  endtask
  // one apb transfer, bounded wait for ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t;
    t = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    @(posedge sys_clk);
    while (pready !== 1'b1) begin
      t++;
      if (t > 16) begin
        fail_count++;
        end_sim();
      end
      @(posedge sys_clk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rdr(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  // reset values and unmapped access
  task automatic t_reset();
    rdr(MIPSS_ENABLE_OFS);
    chk(rd, 32'(MIPSS_ENABLE_RST));
    chk(32'({oct_e, so}), 32'h0);
    rdr(8'h44);
    chk(rd, 32'h0);
    chk(32'(err), 32'h1);
    $display("t_reset done");
  endtask
  // octal bus port drive, float and pull-up
  task automatic t_octal();
    apb(1'b1, MIPSS_OCT_Q_OFS, 32'ha5);
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h04);
    oct_x <= 8'h0f;
    chk(32'({oct_e, oct_o}), 32'hffa5);
    cyc(4);
    rdr(MIPSS_OCT_PIN_OFS);
    chk(rd, 32'h05);
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h0);
    chk(32'(oct_e), 32'h0);
    rdr(MIPSS_OCT_PIN_OFS);
    chk(rd, 32'h0f);
    rdr(MIPSS_OCT_Q_OFS);
    chk(rd, 32'ha5);
    $display("t_octal done");
  endtask
  // latched ports keep program data only
  task automatic t_latch();
    aux8_x <= 8'h00;
    apb(1'b1, MIPSS_AUX8_OFS, 32'h3c);
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h80);
    apb(1'b1, MIPSS_DIR4_OFS, 32'h35);
    chk(32'({aux8_e, gen4_e, aux4_e}), 32'hff53);
    rdr(MIPSS_AUX8_OFS);
    chk(rd, 32'h3c);
    apb(1'b1, MIPSS_GEN4_OFS, 32'hf);
    gen4_x <= 4'h9;
    cyc(4);
    rdr(MIPSS_GEN4_PIN_OFS);
    chk(rd, 32'h09);
    rdr(MIPSS_GEN4_OFS);
    chk(rd, 32'h0f);
    gen4_x <= 4'h0;
    apb(1'b1, MIPSS_AUX4_OFS, 32'h0);
    rdr(MIPSS_GEN4_PIN_OFS);
    chk(rd, 32'h10);
    rdr(MIPSS_AUX4_PIN_OFS);
    chk(rd, 32'h0c);
    $display("t_latch done");
  endtask
  // input levels, capture latches, interrupt gate
  task automatic t_inputs();
    in_pins <= 4'h6;
    cyc(4);
    rdr(MIPSS_IN_LVL_OFS);
    chk(rd, 32'h6);
    rdr(MIPSS_IN_CAP_OFS);
    chk(rd, 32'h3);
    rdr(MIPSS_IN_CAP_OFS);
    chk(rd, 32'h0);
    in_pins <= 4'h4;
    cyc(4);
    chk(32'(irq), 32'h0);
    in_pins <= 4'h6;
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h82);
    in_pins <= 4'h4;
    cyc(4);
    chk(32'(irq), 32'h1);
    rdr(MIPSS_IRQ_OFS);
    chk(rd, 32'h1);
    $display("t_inputs done");
  endtask
  // digit port loads only on command
  task automatic t_digit();
    apb(1'b1, MIPSS_DIGIT_OFS, 32'h9);
    chk(32'(digit), 32'h0);
    apb(1'b1, MIPSS_DOUT_LOAD_OFS, 32'h0);
    apb(1'b1, MIPSS_DIGIT_OFS, 32'h3);
    chk(32'(digit), 32'h9);
    $display("t_digit done");
  endtask
  // shift mode delay, clock rate, forcing low
  task automatic t_shift();
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h08);
    apb(1'b1, MIPSS_SKL_OFS, 32'h1);
    apb(1'b1, MIPSS_SERIAL_OFS, 32'h0);
    for (n = 0; n < 400 && so !== 1'b1; n++) cyc(1);
    chk(32'(n > 116 && n <= 168), 32'h1);
    if (n >= 400) begin
      end_sim();
    end
    // one clock rise per instruction cycle
    k = 0;
    sclk_prev = sclk;
    repeat (10 * MIPSS_INSTR_CYC) begin
      cyc(1);
      k += int'(sclk === 1'b1 && sclk_prev === 1'b0);
      sclk_prev = sclk;
    end
    chk(32'(k), 32'ha);
    // level bit and enable bit three force both pins low
    apb(1'b1, MIPSS_SKL_OFS, 32'h0);
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h00);
    apb(1'b1, MIPSS_SERIAL_OFS, 32'h0);
    k = 0;
    repeat (5 * MIPSS_INSTR_CYC) begin
      cyc(1);
      k += int'(sclk !== 1'b0 || so !== 1'b0);
    end
    chk(32'(k), 32'h0);
    rdr(MIPSS_SERIAL_OFS);
    chk(rd, 32'hf);
    $display("t_shift done");
  endtask
  // counter mode pulse width and logic outputs
  task automatic t_count();
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h09);
    apb(1'b1, MIPSS_SKL_OFS, 32'h1);
    cyc(2);
    chk(32'({so, sclk}), 32'h3);
    apb(1'b1, MIPSS_SERIAL_OFS, 32'h5);
    si <= 1'b0;
    cyc(120);
    si <= 1'b1;
    cyc(80);
    rdr(MIPSS_SERIAL_OFS);
    chk(rd, 32'h4);
    si <= 1'b0;
    cyc(10);
    si <= 1'b1;
    cyc(80);
    rdr(MIPSS_SERIAL_OFS);
    chk(rd, 32'h4);
    $display("t_count done");
  endtask
  // time base from prescaler, then from line two
  task automatic t_tbase();
    k = 0;
    repeat (20 * MIPSS_INSTR_CYC) begin
      cyc(1);
      k += int'(tick === 1'b1);
    end
    chk(32'(k), 32'h5);
    apb(1'b1, MIPSS_ENABLE_OFS, 32'h40);
    in_pins <= 4'h0;
    k = 0;
    repeat (8 * MIPSS_INSTR_CYC) begin
      cyc(1);
      k += int'(tick === 1'b1);
    end
    chk(32'(k), 32'h1);
    $display("t_tbase done");
  endtask
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    cyc(3);
    t_reset();
    t_octal();
    t_latch();
    t_inputs();
    t_digit();
    t_shift();
    t_count();
    t_tbase();
    end_sim();
  end
endmodule
